/* File: hdl/data_checksum_addr.sv */
// data checksum, frame flags and bus-address register of the serial interface
//
// Summary of operation
// - checksum_on_bit enables calculation when 1; it is 0 after reset
// - enable writes accepted once power-on initialization is done
// - enable writes accepted in idle or ready state
// - enable writes ignored in reception, execution or completion state
// - read-only 16-bit checksum shows crc of bytes since the last frame start, updated per byte; reset zero
// - crc-ccitt kermit: polynomial 0x1021, start value 0x0000
// - input bytes and result reflected, final xor zero
// - "123456789" gives 0x8921, read low byte first
// - "1122334455" gives 0xd367, read low byte first
// - sample command 00 c1 ... 00 01 gives 0xfbbf
// - sample response 80 01 ... 00 00 gives 0x6733
// - while enabled, every command and response byte enters the crc
// - command crc updated before more-bytes flag falls
// - command crc held from flag fall until execute strobe
// - response crc updated before response-pending flag falls
// - response crc held from flag fall until ready request
// - address bits 6:0 read current address, default 0x2e, new one applies next access
// - keep_address_bit 1 stores address persistently, 0 makes it volatile
// - address bits 14:7 read as zero
// - more-bytes flag high until size-field byte count received
// - response-pending flag high until all response data returned
module data_checksum_addr #(
    parameter int SIZE_W = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port from the bus protocol layer
    input wire csum_pkg::reg_req_t reg_req_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // state of the command state machine
    input wire logic init_done_i,
    input wire csum_pkg::cmd_state_t cmd_state_i,
    input wire logic execute_strobe_i,
    input wire logic ready_request_i,
    // data streams: command bytes written, response bytes read
    input wire csum_pkg::byte_beat_t cmd_beat_i,
    input wire csum_pkg::byte_beat_t rsp_beat_i,
    input wire logic rsp_start_i,
    // frame status flags
    output logic more_bytes_o,
    output logic response_pending_o,
    output logic checksum_on_o,
    // bus address and its persistent store
    input wire logic host_access_start_i,
    input wire logic [6:0] nv_address_i,
    input wire logic nv_address_valid_i,
    output logic [6:0] bus_address_o,
    output logic nv_write_o,
    output logic [6:0] nv_address_o
);

    csum_pkg::byte_beat_t beat [csum_pkg::NSTREAM];
    logic frame_open [csum_pkg::NSTREAM];
    logic [SIZE_W-1:0] cnt_r [csum_pkg::NSTREAM];
    logic [SIZE_W-1:0] size_r [csum_pkg::NSTREAM];
    logic [SIZE_W-1:0] size_nxt [csum_pkg::NSTREAM];
    logic done [csum_pkg::NSTREAM];
    logic done_r [csum_pkg::NSTREAM];
    logic flag_r [csum_pkg::NSTREAM];
    logic [15:0] csum_r;
    logic [15:0] csum_nxt;
    logic [15:0] csum_view;
    logic checksum_on_r;
    logic en_accept;
    logic wr_en;
    logic wr_addr;
    logic [6:0] addr_r;
    logic [6:0] pend_addr_r;
    logic pend_r;
    logic nv_loaded_r;

    // the two streams share one counter layout
    assign beat[csum_pkg::STREAM_CMD] = cmd_beat_i;
    assign beat[csum_pkg::STREAM_RSP] = rsp_beat_i;
    assign frame_open[csum_pkg::STREAM_CMD] = cmd_beat_i.valid && (cnt_r[csum_pkg::STREAM_CMD] == '0);
    assign frame_open[csum_pkg::STREAM_RSP] = rsp_start_i;

    // per stream: byte count, size capture and status flag
    for (genvar s = 0; s < csum_pkg::NSTREAM; s++) begin : g_stream
        // size field shifts in while its bytes pass
        always_comb begin
            size_nxt[s] = size_r[s];
            if (cnt_r[s] >= SIZE_W'(csum_pkg::SIZE_FIRST_BYTE)
                    && cnt_r[s] <= SIZE_W'(csum_pkg::SIZE_LAST_BYTE)) begin
                size_nxt[s] = {size_r[s][SIZE_W-9:0], beat[s].data};
            end
        end

        // a short size field still ends the frame once the field is complete
        assign done[s] = beat[s].valid && cnt_r[s] >= SIZE_W'(csum_pkg::SIZE_LAST_BYTE)
            && (cnt_r[s] + SIZE_W'(1)) >= size_nxt[s];

        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                cnt_r[s] <= '0;
                size_r[s] <= '0;
            end else if (done[s]) begin
                cnt_r[s] <= '0;
                size_r[s] <= '0;
            end else if (beat[s].valid) begin
                cnt_r[s] <= cnt_r[s] + SIZE_W'(1);
                size_r[s] <= size_nxt[s];
            end
        end

        // flag falls one edge after the crc took the last byte
        always_ff @(posedge clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                done_r[s] <= 1'b0;
                flag_r[s] <= 1'b0;
            end else begin
                done_r[s] <= done[s];
                if (frame_open[s] && !done[s]) begin
                    flag_r[s] <= 1'b1;
                end else if (done_r[s]) begin
                    flag_r[s] <= 1'b0;
                end
            end
        end
    end

    assign more_bytes_o = flag_r[csum_pkg::STREAM_CMD];
    assign response_pending_o = flag_r[csum_pkg::STREAM_RSP];

    // enable writes only outside a command in flight
    always_comb begin
        case (cmd_state_i)
            csum_pkg::ST_IDLE: en_accept = init_done_i;
            csum_pkg::ST_READY: en_accept = init_done_i;
            default: en_accept = 1'b0;
        endcase
    end

    // register decode
    always_comb begin
        wr_en = 1'b0;
        wr_addr = 1'b0;
        if (reg_req_i.wr && reg_req_i.addr == csum_pkg::CSUM_ENABLE_OFS) begin
            wr_en = 1'b1;
        end else if (reg_req_i.wr && reg_req_i.addr == csum_pkg::BUS_ADDR_OFS) begin
            wr_addr = 1'b1;
        end
    end

    // checksum enable bit
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            checksum_on_r <= 1'b0;
        end else if (wr_en && en_accept) begin
            checksum_on_r <= reg_req_i.wdata[csum_pkg::CHECKSUM_ON_BIT];
        end
    end

    assign checksum_on_o = checksum_on_r;

    // crc over whichever stream carries a byte; they never overlap
    always_comb begin
        csum_nxt = csum_r;
        if (checksum_on_r) begin
            for (int s = 0; s < csum_pkg::NSTREAM; s++) begin
                if (beat[s].valid) begin
                    // restart at each frame's first byte
                    csum_nxt = csum_pkg::crc_step(
                        (cnt_r[s] == '0) ? csum_pkg::CRC_INIT : csum_r,
                        beat[s].data);
                end
            end
        end
    end

    // value holds between frames, so it stays put until execute or ready request
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            csum_r <= csum_pkg::CSUM_RESET;
        end else begin
            csum_r <= csum_nxt;
        end
    end

    // bytes swapped on the way out, so the low byte sent first matches the check values
    assign csum_view = {csum_r[7:0], csum_r[15:8]};

    // persistent address is reloaded just after reset release
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            nv_loaded_r <= 1'b0;
        end else begin
            nv_loaded_r <= 1'b1;
        end
    end

    // new address waits for the next host access so the current one completes
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            addr_r <= csum_pkg::BUS_ADDR_DEFAULT;
            pend_addr_r <= csum_pkg::BUS_ADDR_DEFAULT;
            pend_r <= 1'b0;
        end else begin
            if (!nv_loaded_r && nv_address_valid_i) begin
                addr_r <= nv_address_i;
            end else if (host_access_start_i && pend_r) begin
                addr_r <= pend_addr_r;
            end
            if (wr_addr) begin
                pend_addr_r <= reg_req_i.wdata[csum_pkg::ADDR_FIELD_MSB:0];
                pend_r <= 1'b1;
            end else if (host_access_start_i) begin
                pend_r <= 1'b0;
            end
        end
    end

    assign bus_address_o = addr_r;

    // persistent store write; volatile writes leave the store alone
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            nv_write_o <= 1'b0;
            nv_address_o <= csum_pkg::BUS_ADDR_DEFAULT;
        end else begin
            nv_write_o <= wr_addr && reg_req_i.wdata[csum_pkg::KEEP_ADDRESS_BIT];
            if (wr_addr && reg_req_i.wdata[csum_pkg::KEEP_ADDRESS_BIT]) begin
                nv_address_o <= reg_req_i.wdata[csum_pkg::ADDR_FIELD_MSB:0];
            end
        end
    end

    // read data one cycle after the request; unmapped offsets read zero
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            reg_rdata_o <= '0;
            if (reg_req_i.addr == csum_pkg::CSUM_VALUE_OFS) begin
                reg_rdata_o <= csum_view ^ csum_pkg::CRC_XOROUT;
            end else if (reg_req_i.addr == csum_pkg::CSUM_ENABLE_OFS) begin
                reg_rdata_o[csum_pkg::CHECKSUM_ON_BIT] <= checksum_on_r;
            end else if (reg_req_i.addr == csum_pkg::BUS_ADDR_OFS) begin
                reg_rdata_o[csum_pkg::ADDR_FIELD_MSB:0] <= addr_r;
            end
        end
    end

    // checks
    a_enable_accept: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_en && en_accept |=> checksum_on_o == $past(reg_req_i.wdata[0]))
        else $error("accepted enable write not applied");

    a_enable_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_en && cmd_state_i == csum_pkg::ST_RECEPTION |=> $stable(checksum_on_o))
        else $error("enable changed during reception");

    a_crc_off_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !checksum_on_r && (cmd_beat_i.valid || rsp_beat_i.valid) |=> $stable(csum_r))
        else $error("crc moved while disabled");

    a_crc_first_byte: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        checksum_on_r && cmd_beat_i.valid && cnt_r[0] == '0
        |=> csum_r == csum_pkg::crc_step(csum_pkg::CRC_INIT, $past(cmd_beat_i.data)))
        else $error("crc not restarted at frame start");

    a_cmd_flag_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done[0] && more_bytes_o |=> more_bytes_o ##1 (!more_bytes_o && $stable(csum_r)))
        else $error("more-bytes flag fell before crc settled");

    a_rsp_flag_order: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        done[1] && response_pending_o |=> response_pending_o ##1 !response_pending_o)
        else $error("response flag timing wrong");

    a_csum_idle_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !cmd_beat_i.valid && !rsp_beat_i.valid [*2] |-> $stable(csum_r))
        else $error("checksum changed with no data");

    a_csum_readback: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_req_i.rd && reg_req_i.addr == csum_pkg::CSUM_VALUE_OFS
        |=> reg_rvalid_o && reg_rdata_o == $past(csum_view))
        else $error("checksum readback wrong");

    a_addr_reserved: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_req_i.rd && reg_req_i.addr == csum_pkg::BUS_ADDR_OFS
        |=> reg_rdata_o[14:7] == 8'h00 && reg_rdata_o[6:0] == $past(addr_r))
        else $error("address readback wrong");

    a_addr_apply: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        nv_loaded_r && host_access_start_i && pend_r |=> bus_address_o == $past(pend_addr_r))
        else $error("new address not applied at access");

    a_keep_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_addr |=> nv_write_o == $past(reg_req_i.wdata[15]))
        else $error("persistent store write mismatch");

    // rule checks written against states and constants, not against en_accept above
    a_enable_early: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_en && !init_done_i |=> $stable(checksum_on_o))
        else $error("enable write taken before initialization");

    a_enable_free: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_en && init_done_i
        && (cmd_state_i == csum_pkg::ST_IDLE || cmd_state_i == csum_pkg::ST_READY)
        |=> checksum_on_o == $past(reg_req_i.wdata[csum_pkg::CHECKSUM_ON_BIT]))
        else $error("enable write refused in idle or ready");

    a_crc_next_byte: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        checksum_on_r && cmd_beat_i.valid && cnt_r[csum_pkg::STREAM_CMD] != '0
        |=> csum_r == csum_pkg::crc_step($past(csum_r), $past(cmd_beat_i.data)))
        else $error("command byte not folded into crc");

    a_rsp_first_byte: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        checksum_on_r && rsp_beat_i.valid && cnt_r[csum_pkg::STREAM_RSP] == '0
        |=> csum_r == csum_pkg::crc_step(csum_pkg::CRC_INIT, $past(rsp_beat_i.data)))
        else $error("crc not restarted at response start");

    // a stray byte before execute or ready request would be the only way to move the value
    a_cmd_crc_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !more_bytes_o && !execute_strobe_i && !cmd_beat_i.valid && !rsp_beat_i.valid
        |=> $stable(csum_r))
        else $error("command crc moved before execute");

    a_rsp_crc_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !response_pending_o && !ready_request_i && !cmd_beat_i.valid && !rsp_beat_i.valid
        |=> $stable(csum_r))
        else $error("response crc moved before ready request");

    a_value_readonly: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_req_i.wr && reg_req_i.addr == csum_pkg::CSUM_VALUE_OFS
        && !cmd_beat_i.valid && !rsp_beat_i.valid |=> $stable(csum_r))
        else $error("checksum register took a write");

    a_cmd_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_beat_i.valid && cnt_r[csum_pkg::STREAM_CMD] == '0 |=> more_bytes_o)
        else $error("more-bytes flag not raised at command start");

    a_rsp_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rsp_start_i && !rsp_beat_i.valid |=> response_pending_o)
        else $error("response flag not raised at response start");

    a_addr_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        nv_loaded_r && !host_access_start_i |=> $stable(bus_address_o))
        else $error("bus address changed outside a host access");

    a_volatile_addr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_addr && !reg_req_i.wdata[csum_pkg::KEEP_ADDRESS_BIT] |=> !nv_write_o)
        else $error("volatile address reached the store");

endmodule

/* File: shared/csum_pkg.sv */
// shared constants, types and crc helper for the checksum and bus-address block
package csum_pkg;

    // register offsets on the internal register port
    localparam logic [7:0] CSUM_ENABLE_OFS = 8'h40;
    localparam logic [7:0] CSUM_VALUE_OFS = 8'h44;
    localparam logic [7:0] BUS_ADDR_OFS = 8'h48;

    // field positions
    localparam int CHECKSUM_ON_BIT = 0;
    localparam int KEEP_ADDRESS_BIT = 15;
    localparam int ADDR_FIELD_MSB = 6;
    localparam int ADDR_RSVD_MSB = 14;
    localparam int ADDR_RSVD_LSB = 7;

    // reset values
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2e;
    localparam logic [15:0] CSUM_RESET = 16'h0000;

    // crc-ccitt kermit parameters
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] CRC_XOROUT = 16'h0000;

    // the size field sits in bytes 2..5 of each frame, big-endian
    localparam int SIZE_FIRST_BYTE = 2;
    localparam int SIZE_LAST_BYTE = 5;

    // stream indices
    localparam int NSTREAM = 2;
    localparam int STREAM_CMD = 0;
    localparam int STREAM_RSP = 1;

    // states of the command state machine, owned outside this block
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READY,
        ST_RECEPTION,
        ST_EXECUTION,
        ST_COMPLETION
    } cmd_state_t;

    // one data byte of a command or response
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

    // one register access from the bus protocol layer
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_t;

    // bit-reverse a 16-bit word
    function automatic logic [15:0] reflect16(input logic [15:0] v);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // one byte through the reflected crc, lsb of the byte first
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        logic [15:0] rpoly;
        c = crc ^ {8'h00, d};
        rpoly = reflect16(CRC_POLY);
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ rpoly) : (c >> 1);
        end
        return c;
    endfunction

endpackage

/* File: dv/host_ctrl_model.sv */
// host controller model: register accesses, byte streams and strobes
module host_ctrl_model (
    // clock
    input wire logic clk_i,
    // register port
    output csum_pkg::reg_req_t reg_req_o,
    input wire logic [15:0] reg_rdata_i,
    input wire logic reg_rvalid_i,
    // streams and strobes: start, execute, ready, host access
    output csum_pkg::byte_beat_t cmd_beat_o,
    output csum_pkg::byte_beat_t rsp_beat_o,
    output logic [3:0] strobe_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus at time zero
    initial begin
        reg_req_o = '0;
        cmd_beat_o = '0;
        rsp_beat_o = '0;
        strobe_o = '0;
    end

    // one access; leading edge keeps two calls from driving in one step
    task automatic reg_op(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                          output logic [15:0] d, output logic v);
        @(posedge clk_i);
        #1;
        reg_req_o = '{wr: wr, rd: ~wr, addr: a, wdata: wd};
        @(posedge clk_i);
        #1;
        // released fields must not keep their old value
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~wd};
        d = reg_rdata_i;
        v = reg_rvalid_i;
    endtask

    // steer a beat to the chosen stream
    task automatic put(input logic rsp, input csum_pkg::byte_beat_t b);
        if (rsp) begin
            rsp_beat_o = b;
        end else begin
            cmd_beat_o = b;
        end
    endtask

    // whole frame, one byte per cycle, valid held throughout
    task automatic send(input logic rsp, input logic [7:0] q[$]);
        @(posedge clk_i);
        #1;
        foreach (q[i]) begin
            put(rsp, '{valid: 1'b1, data: q[i]});
            @(posedge clk_i);
            #1;
        end
        put(rsp, '{valid: 1'b0, data: ~q[q.size()-1]});
    endtask

    // one-cycle strobe
    task automatic pulse(input int k);
        @(posedge clk_i);
        #1;
        strobe_o[k] = 1'b1;
        @(posedge clk_i);
        #1;
        strobe_o[k] = 1'b0;
    endtask
endmodule

/* File: dv/data_checksum_addr_bench.sv */
// self-checking bench for the checksum and bus-address block
module data_checksum_addr_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // clock, reset and device-side inputs
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic init_done_i = 1'b0;
    csum_pkg::cmd_state_t cmd_state_i = csum_pkg::ST_IDLE;
    logic [6:0] nv_address_i = 7'h00;
    logic nv_address_valid_i = 1'b0;
    csum_pkg::reg_req_t reg_req;
    csum_pkg::byte_beat_t cmd_beat, rsp_beat;
    logic [3:0] strobe;
    logic [15:0] reg_rdata_o;
    logic reg_rvalid_o, more_bytes_o, response_pending_o, checksum_on_o, nv_write_o;
    logic [6:0] bus_address_o, nv_address_o;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] vec_c[$] = '{8'h00, 8'hc1, 8'h00, 8'h00, 8'h00, 8'h0c,
                             8'h00, 8'h00, 8'h00, 8'h99, 8'h00, 8'h01};
    logic [7:0] vec_r[$] = '{8'h80, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0c,
                             8'h00, 8'h00, 8'h01, 8'h44, 8'h00, 8'h00};

    always #4 clk_i = ~clk_i;

    host_ctrl_model host (.clk_i(clk_i), .reg_req_o(reg_req), .reg_rdata_i(reg_rdata_o),
        .reg_rvalid_i(reg_rvalid_o), .cmd_beat_o(cmd_beat), .rsp_beat_o(rsp_beat),
        .strobe_o(strobe));

    data_checksum_addr dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_req_i(reg_req),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .init_done_i(init_done_i),
        .cmd_state_i(cmd_state_i), .execute_strobe_i(strobe[1]), .ready_request_i(strobe[2]),
        .cmd_beat_i(cmd_beat), .rsp_beat_i(rsp_beat), .rsp_start_i(strobe[0]),
        .more_bytes_o(more_bytes_o), .response_pending_o(response_pending_o),
        .checksum_on_o(checksum_on_o), .host_access_start_i(strobe[3]),
        .nv_address_i(nv_address_i), .nv_address_valid_i(nv_address_valid_i),
        .bus_address_o(bus_address_o), .nv_write_o(nv_write_o), .nv_address_o(nv_address_o));

    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake must not stall the run forever
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] wd);
        logic [15:0] d;
        logic v;
        host.reg_op(1'b1, a, wd, d, v);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic v;
        host.reg_op(1'b0, a, 16'h0000, d, v);
        chk({15'h0000, v}, 16'h0001);
        chk(d, exp);
    endtask

    // flag stays up one cycle past the last byte, then drops
    task automatic frame(input logic rsp, input logic [7:0] q[$]);
        host.send(rsp, q);
        chk(rsp ? response_pending_o : more_bytes_o, 16'h0001);
        @(posedge clk_i);
        #1;
        chk(rsp ? response_pending_o : more_bytes_o, 16'h0000);
    endtask

    // nv store contents are sampled at the first edge after release
    task automatic do_reset(input logic [6:0] nv, input logic nvv);
        nv_address_i = nv;
        nv_address_valid_i = nvv;
        sys_rst_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
    endtask

    // fresh device, checksum on, one unframed ascii string
    task automatic ascii_vec(input string s, input logic [15:0] exp);
        logic [7:0] q[$];
        foreach (s[i]) q.push_back(s[i]);
        do_reset(7'h00, 1'b0);
        wr(csum_pkg::CSUM_ENABLE_OFS, 16'h0001);
        host.send(1'b0, q);
        rd_chk(csum_pkg::CSUM_VALUE_OFS, exp);
    endtask

    initial begin
        do_reset(7'h00, 1'b0);
        chk(checksum_on_o, 16'h0000);
        rd_chk(csum_pkg::CSUM_VALUE_OFS, 16'h0000);
        rd_chk(csum_pkg::BUS_ADDR_OFS, 16'h002e);
        rd_chk(8'h10, 16'h0000);
        frame(1'b0, vec_c);
        rd_chk(csum_pkg::CSUM_VALUE_OFS, 16'h0000);
        wr(csum_pkg::CSUM_ENABLE_OFS, 16'h0001);
        chk(checksum_on_o, 16'h0000);
        init_done_i = 1'b1;
        wr(csum_pkg::CSUM_ENABLE_OFS, 16'h0001);
        chk(checksum_on_o, 16'h0001);
        // busy states must drop a write to the enable
        for (int s = 2; s <= 4; s++) begin
            cmd_state_i = csum_pkg::cmd_state_t'(s);
            wr(csum_pkg::CSUM_ENABLE_OFS, 16'h0000);
            chk(checksum_on_o, 16'h0001);
        end
        cmd_state_i = csum_pkg::ST_READY;
        wr(csum_pkg::CSUM_ENABLE_OFS, 16'h0000);
        chk(checksum_on_o, 16'h0000);
        cmd_state_i = csum_pkg::ST_IDLE;
        wr(csum_pkg::CSUM_ENABLE_OFS, 16'h00ff);
        rd_chk(csum_pkg::CSUM_ENABLE_OFS, 16'h0001);
        frame(1'b0, vec_c);
        rd_chk(csum_pkg::CSUM_VALUE_OFS, 16'hfbbf);
        repeat (8) @(posedge clk_i);
        host.pulse(1);
        rd_chk(csum_pkg::CSUM_VALUE_OFS, 16'hfbbf);
        host.pulse(0);
        chk(response_pending_o, 16'h0001);
        frame(1'b1, vec_r);
        rd_chk(csum_pkg::CSUM_VALUE_OFS, 16'h6733);
        repeat (8) @(posedge clk_i);
        host.pulse(2);
        wr(csum_pkg::CSUM_VALUE_OFS, 16'hffff);
        rd_chk(csum_pkg::CSUM_VALUE_OFS, 16'h6733);
        // volatile address with reserved bits set
        wr(csum_pkg::BUS_ADDR_OFS, 16'h7fb3);
        chk(nv_write_o, 16'h0000);
        rd_chk(csum_pkg::BUS_ADDR_OFS, 16'h002e);
        host.pulse(3);
        @(posedge clk_i);
        #1;
        chk(bus_address_o, 16'h0033);
        rd_chk(csum_pkg::BUS_ADDR_OFS, 16'h0033);
        wr(csum_pkg::BUS_ADDR_OFS, 16'h8055);
        chk(nv_write_o, 16'h0001);
        chk(nv_address_o, 16'h0055);
        do_reset(7'h00, 1'b0);
        rd_chk(csum_pkg::BUS_ADDR_OFS, 16'h002e);
        do_reset(7'h55, 1'b1);
        rd_chk(csum_pkg::BUS_ADDR_OFS, 16'h0055);
        ascii_vec("123456789", 16'h8921);
        ascii_vec("1122334455", 16'hd367);
        results();
    end
endmodule
